// ### hw/tkm_params.svh
// register offsets, field positions, reset values and timing counts for the touch measurement unit
// Function
// - frequency select picks 1, 3, 7 or 11 MHz; resets to code 11
// - function counter stops and holds its value on slot overflow
// - sense counter stops and holds its value on slot overflow
// - start low clears sense, function and unit counters, not the slot counter
// - ten-bit trim sets reference capacitance as code times 30pF over 1024
// - pad select 00 picks first pad, 01 second pad, others reserved
// - frequency double bit doubles the sense oscillator frequency
// - filter bit enables the module filter, resets disabled
// - hopping source 1 gives hardware hopping, 0 uses the hop select field
// - hop select sets oscillators from 1.020 to 1.125 MHz in eight steps
// - slot clock source: reference oscillator at 0, system clock over 4 at 1
// - separate enables switch reference and sense oscillators, both reset off
// - pad enable bits 0 and 1 admit pads into measurement
// - start rising edge switches on all four counters together
// - slot overflow stops oscillators and switches off all four counters
// - touch interrupt raised exactly on slot counter overflow
// - count sense cycles during fixed interval from divided reference clock
// - each pad has its own independent sense oscillator
// - unimplemented bits read zero and ignore writes
// - interval is (256 minus preload) times 32 slot clock periods
// - overflow sets slot flag and interrupt; software write cannot set it
// - function counter clock is system clock over 1, 2, 4 or 8
// - sticky overflow flags for sense and function counters, software clears
`ifndef TKM_PARAMS_SVH
`define TKM_PARAMS_SVH

// ******************************
// register byte offsets
// ******************************
`define TKM_OFS_PRELOAD 12'h000
`define TKM_OFS_CTRL 12'h004
`define TKM_OFS_FREQ 12'h008
`define TKM_OFS_FCNT_LO 12'h00c
`define TKM_OFS_FCNT_HI 12'h010
`define TKM_OFS_SCNT_LO 12'h014
`define TKM_OFS_SCNT_HI 12'h018
`define TKM_OFS_TRIM_LO 12'h01c
`define TKM_OFS_TRIM_HI 12'h020
`define TKM_OFS_MCTL_A 12'h024
`define TKM_OFS_MCTL_B 12'h028

// ******************************
// field positions
// ******************************
`define TKM_CTRL_SLOT_OVF 6
`define TKM_CTRL_START 5
`define TKM_CTRL_SCNT_OVF 4
`define TKM_CTRL_FCNT_OVF 3
`define TKM_MCTLB_SLOT_SRC 7
`define TKM_MCTLB_REF_EN 5
`define TKM_MCTLB_SENSE_EN 4
`define TKM_MCTLB_PAD_B_EN 1
`define TKM_MCTLB_PAD_A_EN 0

// ******************************
// reset values and counts
// ******************************
`define TKM_FREQ_RST 2'h3
`define TKM_PAD_SEL_A 2'h0
`define TKM_PAD_SEL_B 2'h1
`define TKM_UNIT_LAST 5'h1f
`define TKM_SLOT_LAST 8'hff
`define TKM_CNT_LAST 16'hffff
`define TKM_SLOT_DIV_LAST 3'h3

`endif

// ### hw/tkm_pkg.sv
// types shared by the touch measurement unit
package tkm_pkg;

  // measurement sequencer
  typedef enum logic [1:0] {
    TKM_IDLE = 2'b00,
    TKM_RUN = 2'b01,
    TKM_DONE = 2'b10
  } tkm_state_t;

  // oscillator clocks arriving from the analog side
  typedef struct packed {
    logic ref_osc;
    logic pad_b_osc;
    logic pad_a_osc;
  } tkm_osc_in_t;

  // controls driven to the analog oscillators
  typedef struct packed {
    logic [1:0] osc_freq_sel;
    logic [2:0] hop_freq;
    logic freq_double_en;
    logic filter_en;
    logic [9:0] ref_cap_trim;
    logic ref_run;
    logic pad_a_run;
    logic pad_b_run;
  } tkm_osc_ctrl_t;

endpackage

// ### hw/tkm_top.sv
// capacitive touch measurement unit with apb register access
`timescale 1ns/1ps
`include "tkm_params.svh"

module tkm_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire tkm_pkg::tkm_osc_in_t osc_in,
  output tkm_pkg::tkm_osc_ctrl_t osc_ctrl,
  // interrupt request to the system controller
  output logic touch_irq
);

  // ******************************
  // register state
  // ******************************
  logic [7:0] preload_ff;
  logic [1:0] fcnt_clk_sel_ff;
  logic start_ff;
  logic start_q_ff;
  logic slot_ovf_ff;
  logic scnt_ovf_ff;
  logic fcnt_ovf_ff;
  logic [1:0] freq_sel_ff;
  logic [9:0] trim_ff;
  logic [7:0] mctl_a_ff;
  logic [7:0] mctl_b_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  tkm_pkg::tkm_osc_ctrl_t osc_ctrl_ff;
  logic touch_irq_ff;

  // measurement state
  tkm_pkg::tkm_state_t state_ff;
  logic [2:0] div_ff;
  logic [4:0] unit_ff;
  logic [7:0] slot_ff;
  logic [15:0] scnt_ff;
  logic [15:0] fcnt_ff;
  logic [2:0] hw_hop_ff;
  logic [2:0] osc_s1_ff;
  logic [2:0] osc_s2_ff;
  logic [2:0] osc_s3_ff;

  logic start_rise;
  logic running;
  logic slot_tick;
  logic fcnt_tick;
  logic sense_edge;
  logic slot_done;
  logic [2:0] osc_edge;
  logic acc_ok;
  logic addr_hit;
  logic wr_en;
  logic [31:0] rd_mux;

  // field aliases
  logic [1:0] pad_mux_sel;
  logic hop_ctrl_src;
  logic [2:0] hop_freq_sel;
  logic slot_clk_src;
  logic ref_osc_en;
  logic sense_osc_en;
  logic pad_a_en;
  logic pad_b_en;

  assign pad_mux_sel = mctl_a_ff[7:6];
  assign hop_ctrl_src = mctl_a_ff[3];
  assign hop_freq_sel = mctl_a_ff[2:0];
  assign slot_clk_src = mctl_b_ff[`TKM_MCTLB_SLOT_SRC];
  assign ref_osc_en = mctl_b_ff[`TKM_MCTLB_REF_EN];
  assign sense_osc_en = mctl_b_ff[`TKM_MCTLB_SENSE_EN];
  assign pad_a_en = mctl_b_ff[`TKM_MCTLB_PAD_A_EN];
  assign pad_b_en = mctl_b_ff[`TKM_MCTLB_PAD_B_EN];

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign osc_ctrl = osc_ctrl_ff;
  assign touch_irq = touch_irq_ff;

  // ******************************
  // apb slave
  // ******************************

  // address decode; anything else answers with pslverr and zero data
  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      `TKM_OFS_PRELOAD: rd_mux = {24'h000000, preload_ff};
      `TKM_OFS_CTRL: rd_mux = {25'h0000000, slot_ovf_ff, start_ff, scnt_ovf_ff,
                               fcnt_ovf_ff, 1'b0, fcnt_clk_sel_ff};
      `TKM_OFS_FREQ: rd_mux = {30'h00000000, freq_sel_ff};
      `TKM_OFS_FCNT_LO: rd_mux = {24'h000000, fcnt_ff[7:0]};
      `TKM_OFS_FCNT_HI: rd_mux = {24'h000000, fcnt_ff[15:8]};
      `TKM_OFS_SCNT_LO: rd_mux = {24'h000000, scnt_ff[7:0]};
      `TKM_OFS_SCNT_HI: rd_mux = {24'h000000, scnt_ff[15:8]};
      `TKM_OFS_TRIM_LO: rd_mux = {24'h000000, trim_ff[7:0]};
      `TKM_OFS_TRIM_HI: rd_mux = {30'h00000000, trim_ff[9:8]};
      `TKM_OFS_MCTL_A: rd_mux = {24'h000000, mctl_a_ff};
      `TKM_OFS_MCTL_B: rd_mux = {24'h000000, mctl_b_ff};
      default: begin
        rd_mux = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
  end

  // the access phase completes on the edge where our registered pready is high
  assign acc_ok = psel & penable & pready_ff;
  assign wr_en = acc_ok & pwrite & addr_hit;

  // answer one cycle after setup: pready, data and error all from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~addr_hit;
      prdata_ff <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ******************************
  // software registers
  // ******************************

  // plain read/write fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preload_ff <= 8'h00;
      fcnt_clk_sel_ff <= 2'h0;
      start_ff <= 1'b0;
      freq_sel_ff <= `TKM_FREQ_RST;
      trim_ff <= 10'h000;
      mctl_a_ff <= 8'h00;
      mctl_b_ff <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        `TKM_OFS_PRELOAD: preload_ff <= pwdata[7:0];
        `TKM_OFS_CTRL: begin
          start_ff <= pwdata[`TKM_CTRL_START];
          fcnt_clk_sel_ff <= pwdata[1:0];
        end
        `TKM_OFS_FREQ: freq_sel_ff <= pwdata[1:0];
        // trim code held for the analog array
        `TKM_OFS_TRIM_LO: trim_ff[7:0] <= pwdata[7:0];
        `TKM_OFS_TRIM_HI: trim_ff[9:8] <= pwdata[1:0];
        `TKM_OFS_MCTL_A: mctl_a_ff <= pwdata[7:0];
        `TKM_OFS_MCTL_B: mctl_b_ff <= pwdata[7:0] & 8'hb3;
        default: start_ff <= start_ff;
      endcase
    end
  end

  // sticky flags: software may only clear, hardware set wins same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_ovf_ff <= 1'b0;
      scnt_ovf_ff <= 1'b0;
      fcnt_ovf_ff <= 1'b0;
    end else begin
      // write of one cannot set the slot flag
      slot_ovf_ff <= ((wr_en && paddr == `TKM_OFS_CTRL) ?
                      slot_ovf_ff & pwdata[`TKM_CTRL_SLOT_OVF] : slot_ovf_ff) | slot_done;
      scnt_ovf_ff <= ((wr_en && paddr == `TKM_OFS_CTRL) ?
                      scnt_ovf_ff & pwdata[`TKM_CTRL_SCNT_OVF] : scnt_ovf_ff)
                     | (running & sense_edge & (scnt_ff == `TKM_CNT_LAST));
      fcnt_ovf_ff <= ((wr_en && paddr == `TKM_OFS_CTRL) ?
                      fcnt_ovf_ff & pwdata[`TKM_CTRL_FCNT_OVF] : fcnt_ovf_ff)
                     | (running & fcnt_tick & (fcnt_ff == `TKM_CNT_LAST));
    end
  end

  // ******************************
  // oscillator input synchronisers
  // ******************************

  // two flops per oscillator, third flop only for edge detection
  // each pad oscillator has its own path
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          osc_s1_ff[gi] <= 1'b0;
          osc_s2_ff[gi] <= 1'b0;
          osc_s3_ff[gi] <= 1'b0;
        end else begin
          osc_s1_ff[gi] <= osc_in[gi];
          osc_s2_ff[gi] <= osc_s1_ff[gi];
          osc_s3_ff[gi] <= osc_s2_ff[gi];
        end
      end
      assign osc_edge[gi] = osc_s2_ff[gi] & ~osc_s3_ff[gi];
    end
  endgenerate

  // ******************************
  // measurement sequencer
  // ******************************
  assign start_rise = start_ff & ~start_q_ff;
  assign running = (state_ff == tkm_pkg::TKM_RUN);

  // slot clock from reference oscillator or system clock over four
  assign slot_tick = slot_clk_src ? (div_ff[1:0] == 2'(`TKM_SLOT_DIV_LAST))
                                  : (osc_edge[2] & ref_osc_en);

  always_comb begin
    case (fcnt_clk_sel_ff)
      2'h0: fcnt_tick = 1'b1;
      2'h1: fcnt_tick = div_ff[0];
      2'h2: fcnt_tick = &div_ff[1:0];
      default: fcnt_tick = &div_ff;
    endcase
  end

  // selected pad only; disabled pads never count; reserved codes count nothing
  always_comb begin
    case (pad_mux_sel)
      `TKM_PAD_SEL_A: sense_edge = osc_edge[0] & pad_a_en & sense_osc_en;
      `TKM_PAD_SEL_B: sense_edge = osc_edge[1] & pad_b_en & sense_osc_en;
      default: sense_edge = 1'b0;
    endcase
  end

  // last unit period of the last slot step ends the interval
  assign slot_done = running & slot_tick & (unit_ff == `TKM_UNIT_LAST)
                     & (slot_ff == `TKM_SLOT_LAST);

  // sequencer; a new run needs start to drop and rise again
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= tkm_pkg::TKM_IDLE;
      start_q_ff <= 1'b0;
    end else begin
      start_q_ff <= start_ff;
      case (state_ff)
        // rising start switches all counters on
        tkm_pkg::TKM_IDLE: if (start_rise) begin
          state_ff <= tkm_pkg::TKM_RUN;
        end
        tkm_pkg::TKM_RUN: begin
          if (!start_ff) begin
            state_ff <= tkm_pkg::TKM_IDLE;
          end else if (slot_done) begin
            state_ff <= tkm_pkg::TKM_DONE;
          end
        end
        tkm_pkg::TKM_DONE: if (!start_ff) begin
          state_ff <= tkm_pkg::TKM_IDLE;
        end
        default: state_ff <= tkm_pkg::TKM_IDLE;
      endcase
    end
  end

  // free running divider shared by slot and function clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // unit and slot counters form the fixed interval
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unit_ff <= 5'h00;
      slot_ff <= 8'h00;
    end else begin
      // unit cleared while start low, slot counter left alone
      if (!start_ff) begin
        unit_ff <= 5'h00;
      end else if (running && slot_tick) begin
        unit_ff <= unit_ff + 5'h01;
      end
      if (start_rise) begin
        slot_ff <= preload_ff;
      end else if (running && slot_tick && unit_ff == `TKM_UNIT_LAST) begin
        slot_ff <= slot_ff + 8'h01;
      end
    end
  end

  // sense and function counters; both freeze once the run ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scnt_ff <= 16'h0000;
      fcnt_ff <= 16'h0000;
    end else begin
      if (!start_ff) begin
        scnt_ff <= 16'h0000;
        fcnt_ff <= 16'h0000;
      end else begin
        if (running && sense_edge) begin
          scnt_ff <= scnt_ff + 16'h0001;
        end
        if (running && fcnt_tick) begin
          fcnt_ff <= fcnt_ff + 16'h0001;
        end
      end
    end
  end

  // hardware hopping steps to a new code at each measurement start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hw_hop_ff <= 3'h0;
    end else if (start_rise && hop_ctrl_src) begin
      hw_hop_ff <= hw_hop_ff + 3'h1;
    end
  end

  // ******************************
  // analog controls and interrupt
  // ******************************

  // controls registered so the analog side never sees decode glitches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_ctrl_ff <= '0;
      osc_ctrl_ff.osc_freq_sel <= `TKM_FREQ_RST;
    end else begin
      // frequency code passed to both oscillators
      osc_ctrl_ff.osc_freq_sel <= freq_sel_ff;
      // software hop code unless hardware owns it
      osc_ctrl_ff.hop_freq <= hop_ctrl_src ? hw_hop_ff : hop_freq_sel;
      osc_ctrl_ff.freq_double_en <= mctl_a_ff[5];
      osc_ctrl_ff.filter_en <= mctl_a_ff[4];
      osc_ctrl_ff.ref_cap_trim <= trim_ff;
      // enables gate each oscillator; stopped outside a run
      osc_ctrl_ff.ref_run <= ref_osc_en & running & ~slot_done;
      osc_ctrl_ff.pad_a_run <= sense_osc_en & pad_a_en & running & ~slot_done;
      osc_ctrl_ff.pad_b_run <= sense_osc_en & pad_b_en & running & ~slot_done;
    end
  end

  // one-cycle interrupt request on slot overflow only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      touch_irq_ff <= 1'b0;
    end else begin
      touch_irq_ff <= slot_done;
    end
  end

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_freq_after_reset: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> freq_sel_ff == 2'h3)
    else $error("frequency select not at reset code");
  a_fcnt_frozen: assert property (
    state_ff == tkm_pkg::TKM_DONE && start_ff ##1 start_ff |-> $stable(fcnt_ff))
    else $error("function counter moved after overflow");
  a_scnt_frozen: assert property (
    state_ff == tkm_pkg::TKM_DONE && start_ff ##1 start_ff |-> $stable(scnt_ff))
    else $error("sense counter moved after overflow");
  a_stop_clears: assert property (
    !start_ff |=> scnt_ff == 16'h0000 && fcnt_ff == 16'h0000 && unit_ff == 5'h00)
    else $error("counters not cleared while start low");
  a_slot_kept: assert property (
    !start_ff && !running ##1 !start_ff |-> $stable(slot_ff))
    else $error("slot counter changed while start low");
  a_start_runs: assert property (
    start_rise && state_ff == tkm_pkg::TKM_IDLE |=> running)
    else $error("start edge did not begin a run");
  a_osc_stopped: assert property (
    state_ff == tkm_pkg::TKM_DONE |=> !osc_ctrl_ff.ref_run && !osc_ctrl_ff.pad_a_run
      && !osc_ctrl_ff.pad_b_run)
    else $error("oscillators still running after overflow");
  a_irq_exact: assert property (
    touch_irq_ff |-> $past(slot_done) && slot_ovf_ff && state_ff == tkm_pkg::TKM_DONE)
    else $error("interrupt without slot overflow");
  a_flag_no_set: assert property (
    !slot_ovf_ff && !slot_done |=> !slot_ovf_ff)
    else $error("slot flag set without overflow");
  a_mux_reserved: assert property (
    running && pad_mux_sel[1] |=> $stable(scnt_ff))
    else $error("reserved pad select counted");

  c_full_run: cover property (running ##1 state_ff == tkm_pkg::TKM_DONE ##1 touch_irq_ff);
  c_scnt_wrap: cover property (running && sense_edge && scnt_ff == 16'hffff);
  c_hw_hop: cover property (start_rise && hop_ctrl_src);
  c_abort: cover property (running ##1 !start_ff);

endmodule

// ### tb/tb_tkm_top.sv
// self-checking bench for the touch measurement unit
`timescale 1ns/1ps
`include "tkm_params.svh"

module tb_tkm_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, touch_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  tkm_pkg::tkm_osc_in_t osc_in;
  tkm_pkg::tkm_osc_ctrl_t osc_ctrl;
  int half_ref = 2, half_a = 3, half_b = 5;
  int mismatches = 0, checks_done = 0;
  logic [2:0] run_mid;

  tkm_top uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_in(osc_in), .osc_ctrl(osc_ctrl), .touch_irq(touch_irq));
  tkm_osc_model osc_model (.clk(clk), .ctrl(osc_ctrl), .half_ref(half_ref),
    .half_a(half_a), .half_b(half_b), .osc(osc_in));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // window compare, since oscillator phase and syncing blur the edges
  task automatic rng(input string nm, input logic [31:0] v, input int lo, input int hi);
    // a window reaching below zero has no lower bound on an unsigned count
    chk(nm, {31'h0, ((lo <= 0 || v >= lo) && v <= hi)}, 32'h1);
  endtask

  // one apb transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task automatic rd16(input logic [11:0] a, output logic [15:0] v);
    logic [31:0] l, h;
    rd(a, l);
    rd(a + 12'h004, h);
    v = {h[7:0], l[7:0]};
  endtask

  // start a run and count clocks up to the interrupt pulse
  task automatic measure(input logic [7:0] ctl, output int cyc);
    wr(`TKM_OFS_CTRL, 8'h00);
    wr(`TKM_OFS_CTRL, ctl);
    cyc = 0;
    while (touch_irq !== 1'b1 && cyc < 90000) begin
      @(posedge clk);
      cyc++;
      if (cyc == 8) run_mid = {osc_ctrl.ref_run, osc_ctrl.pad_a_run, osc_ctrl.pad_b_run};
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    // reset code and every frequency code
    rd(`TKM_OFS_FREQ, d); chk("freq_rst", d, 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(`TKM_OFS_FREQ, 8'hfc | c[7:0]);
      rd(`TKM_OFS_FREQ, d); chk("freq_rd", d, c);
      chk("freq_out", osc_ctrl.osc_freq_sel, c);
    end
    rd(`TKM_OFS_MCTL_B, d); chk("mctlb_rst", d, 32'h0);
    wr(`TKM_OFS_MCTL_B, 8'hff);
    rd(`TKM_OFS_MCTL_B, d); chk("mctlb_rd", d, 32'hb3);
    wr(`TKM_OFS_TRIM_LO, 8'ha5);
    wr(`TKM_OFS_TRIM_HI, 8'hfe);
    rd(`TKM_OFS_TRIM_HI, d); chk("trim_hi", d, 32'h2);
    chk("trim_out", osc_ctrl.ref_cap_trim, 32'h2a5);
    for (int c = 0; c < 8; c++) begin
      wr(`TKM_OFS_MCTL_A, 8'h30 | c[7:0]);
      // analog controls lag the register by one clock
      @(posedge clk);
      chk("hop_out", osc_ctrl.hop_freq, c);
    end
    chk("double", osc_ctrl.freq_double_en, 32'h1);
    chk("filter", osc_ctrl.filter_en, 32'h1);
    apb(1'b1, 12'h02c, 32'hff, d, e); chk("unmap_err", e, 32'h1);
    apb(1'b0, 12'h02c, 32'h0, d, e); chk("unmap_rd", d, 32'h0);
    wr(`TKM_OFS_FCNT_LO, 8'h55);
    rd(`TKM_OFS_FCNT_LO, d); chk("fcnt_ro", d, 32'h0);
  endtask

  // runs on system clock over four, 256 clk each, pad table
  task automatic t_sys_runs();
    logic [7:0] mcta[4] = '{8'h08, 8'h40, 8'h80, 8'h00};
    logic [7:0] mctb[4] = '{8'h91, 8'h93, 8'h93, 8'h92};
    int exp_s[4] = '{42, 25, 0, 0};
    logic [2:0] exp_run[4] = '{3'h2, 3'h3, 3'h3, 3'h1};
    logic [2:0] h0;
    logic [15:0] f, s, f2, s2;
    logic [31:0] d;
    int cyc;
    wr(`TKM_OFS_PRELOAD, 8'hfe);
    for (int i = 0; i < 4; i++) begin
      wr(`TKM_OFS_MCTL_A, mcta[i]);
      wr(`TKM_OFS_MCTL_B, mctb[i]);
      h0 = osc_ctrl.hop_freq;
      measure(8'h20 | i[7:0], cyc);
      rng("slot_len", cyc, 248, 268);
      chk("run_mid", run_mid, exp_run[i]);
      if (i == 0) chk("hw_hop", osc_ctrl.hop_freq, h0 + 3'h1);
      chk("run_off", {osc_ctrl.ref_run, osc_ctrl.pad_a_run, osc_ctrl.pad_b_run}, 0);
      rd(`TKM_OFS_CTRL, d); chk("slot_flag", d[6], 32'h1);
      rd16(`TKM_OFS_FCNT_LO, f);
      rng("fcnt", f, (256 >> i) - 6, (256 >> i) + 6);
      rd16(`TKM_OFS_SCNT_LO, s);
      rng("scnt", s, exp_s[i] - 3, exp_s[i] + 3);
      repeat (30) @(posedge clk);
      rd16(`TKM_OFS_FCNT_LO, f2); chk("fcnt_hold", f2, f);
      rd16(`TKM_OFS_SCNT_LO, s2); chk("scnt_hold", s2, s);
    end
    wr(`TKM_OFS_CTRL, 8'h40);
    rd16(`TKM_OFS_FCNT_LO, f); chk("fcnt_clr", f, 32'h0);
    rd16(`TKM_OFS_SCNT_LO, s); chk("scnt_clr", s, 32'h0);
    rd(`TKM_OFS_CTRL, d); chk("flag_kept", d[6], 32'h1);
    wr(`TKM_OFS_CTRL, 8'h00);
    wr(`TKM_OFS_CTRL, 8'h40);
    rd(`TKM_OFS_CTRL, d); chk("flag_noset", d[6], 32'h0);
    chk("irq_quiet", touch_irq, 32'h0);
  endtask

  // long run on the reference oscillator, function counter wraps
  task automatic t_ref_run();
    logic [31:0] d;
    int cyc;
    half_ref = 10;
    wr(`TKM_OFS_PRELOAD, 8'h80);
    wr(`TKM_OFS_MCTL_A, 8'h00);
    wr(`TKM_OFS_MCTL_B, 8'h31);
    measure(8'h20, cyc);
    rng("ref_len", cyc, 81900, 82000);
    chk("ref_mid", run_mid, 3'h6);
    rd(`TKM_OFS_CTRL, d);
    chk("fcnt_ovf", d[3], 32'h1);
    chk("scnt_no_ovf", d[4], 32'h0);
    wr(`TKM_OFS_CTRL, 8'h00);
    rd(`TKM_OFS_CTRL, d); chk("flags_clr", d, 32'h0);
  endtask

  // ****************************************
  // sequence, verdict and watchdog
  // ****************************************
  task automatic give_verdict();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run_mid = 3'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sys_runs();
    t_ref_run();
    give_verdict();
  end

  // hang guard, well beyond the longest run
  initial begin
    #(98000 * 4);
    mismatches++;
    give_verdict();
  end
endmodule

// ### tb/tkm_osc_model.sv
// behavioural reference and sense pad oscillators facing the touch unit
`timescale 1ns/1ps

module tkm_osc_model (
  // clock
  input wire logic clk,
  // controls from the unit, half periods in clk cycles
  input wire tkm_pkg::tkm_osc_ctrl_t ctrl,
  input wire logic [31:0] half_ref,
  input wire logic [31:0] half_a,
  input wire logic [31:0] half_b,
  // square waves to the unit
  output tkm_pkg::tkm_osc_in_t osc
);
  // ****************************************
  // oscillators
  // ****************************************
  int cnt[3] = '{0, 0, 0};
  int half[3];
  logic [2:0] run;
  logic [2:0] wave = 3'h0;

  // index 0 pad a, 1 pad b, 2 reference, as in the packed struct
  assign run = {ctrl.ref_run, ctrl.pad_b_run, ctrl.pad_a_run};
  assign osc = wave;
  always_comb begin
    half[0] = int'(half_a);
    half[1] = int'(half_b);
    half[2] = int'(half_ref);
  end

  // own wave per oscillator, still and low while not running
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!run[i]) begin
        cnt[i] <= 0;
        wave[i] <= 1'b0;
      end else if (cnt[i] >= half[i] - 1) begin
        cnt[i] <= 0;
        wave[i] <= ~wave[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
